// >>> rtl/pic_params.svh
// offsets, field positions, reset values and vector numbers of the arbiter
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PIC_ADDR_W          4
`define PIC_DATA_W          16
`define PIC_OFS_LEVEL0      4'h0
`define PIC_OFS_LEVEL1      4'h1
`define PIC_OFS_VBASE       4'h7
`define PIC_OFS_FAST0       4'h8
`define PIC_OFS_FAST1       4'h9
`define PIC_OFS_CTRL        4'ha

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PIC_F_CLKGEN        14
`define PIC_F_LOWVOLT       12
`define PIC_F_DBG_RX        8
`define PIC_F_DBG_TX        6
`define PIC_F_DBG_TRACE     4
`define PIC_F_DBG_BKPT      2
`define PIC_F_DBG_STEP      0
`define PIC_LEVEL0_WMASK    16'hf3ff
`define PIC_VBASE_WMASK     16'h3fff
`define PIC_LEVEL_RESET     16'h0000
`define PIC_FAST_RESET      7'h00
`define PIC_VBASE_DEFAULT   14'h0000

// ----------------------------------------------------------------
// vector numbers
// ----------------------------------------------------------------
`define PIC_VEC_W           7
`define PIC_NUM_VEC         26
`define PIC_VEC_CHIP_RST    7'h00
`define PIC_VEC_WDOG_RST    7'h01
`define PIC_VEC_CORE_FIRST  7'h02
`define PIC_VEC_CORE_LAST   7'h05
`define PIC_VEC_DBG_STEP    7'h06
`define PIC_VEC_DBG_BKPT    7'h07
`define PIC_VEC_DBG_TRACE   7'h08
`define PIC_VEC_DBG_TX      7'h09
`define PIC_VEC_DBG_RX      7'h0a
`define PIC_VEC_SOFT2       7'h0b
`define PIC_VEC_SOFT1       7'h0c
`define PIC_VEC_SOFT_LOW    7'h0d
`define PIC_VEC_CLKGEN      7'h10
`define PIC_VEC_LOWVOLT     7'h11
`define PIC_VEC_PERIPH      7'h12
`define PIC_NUM_PERIPH      8

`endif

// >>> rtl/pic_pkg.sv
// types shared by the interrupt arbiter and its bench
package pic_pkg;

  typedef logic [1:0] pic_level_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } pic_bus_req_t;

  typedef struct packed {
    logic        request;
    logic        fast;
    logic [1:0]  level_code;
    logic [6:0]  vector;
    logic [20:0] vector_addr;
  } pic_core_out_t;

  typedef struct packed {
    logic       en;
    pic_level_t lvl;
  } pic_src_t;

endpackage

// >>> rtl/pic_irq_arbiter.sv
// priority interrupt arbiter with register bank and vector forming
//
// Notes on behaviour
// [RQ1] higher level always served before lower
// [RQ2] same level: smallest vector number wins
// [RQ3] vector address is base concatenated with vector
// [RQ4] table follows base; resets use entries 0,1
// [RQ5] core exceptions 2-5 fixed at level 3
// [RQ6] debug sources 6-10 programmable levels 1-3
// [RQ7] higher-level request accepted during handling
// [RQ8] core mask bits gate acceptable levels
// [RQ9] presented level reported as two-bit code
// [RQ10] fast interrupt: level 2 matching match register
// [RQ11] software sets level 2 and match vector
// [RQ12] level fields reset to disabled; 01..11 levels
// [RQ13] clockgen 15-14, low voltage 13-12
// [RQ14] debug rx 9-8, debug tx 7-6
// [RQ15] trace 5-4, breakpoint 3-2, step 1-0
// [RQ16] software writes zero to bits 11-10
// [RQ17] disabled sources never join arbitration
// [RQ18] base bits 15-14 zero, resets to zero
`timescale 1ns/10ps
`include "pic_params.svh"

module pic_irq_arbiter #(
  parameter logic [13:0] VBASE_RESET = `PIC_VBASE_DEFAULT
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire pic_pkg::pic_bus_req_t bus_req,
  output      logic [15:0]           rd_data,
  input  wire logic [25:0]           irq_req,
  input  wire logic                  mask_bit_high,
  input  wire logic                  mask_bit_low,
  output      pic_pkg::pic_core_out_t core_out,
  output      logic [20:0]           chip_rst_addr,
  output      logic [20:0]           wdog_rst_addr
);
  import pic_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (`PIC_NUM_VEC > (1 << `PIC_VEC_W)) begin : g_chk_vec
    $error("vector count exceeds vector width");
  end
  if ((`PIC_VEC_PERIPH + `PIC_NUM_PERIPH) != `PIC_NUM_VEC)
  begin : g_chk_map
    $error("peripheral vectors do not fill the map");
  end

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // debug and clock fields: code equals level, 00 is off
  function automatic pic_src_t prog_level(
    input logic [1:0] code
  );
    pic_src_t s;
    s.en  = (code != 2'b00); // RQ12
    s.lvl = code;            // RQ6
    return s;
  endfunction

  // peripheral fields: levels 0-2, 00 is off
  function automatic pic_src_t periph_level(
    input logic [1:0] code
  );
    pic_src_t s;
    s.en  = (code != 2'b00);
    s.lvl = code - 2'b01;
    return s;
  endfunction

  function automatic logic [20:0] form_addr(
    input logic [13:0] base,
    input logic [6:0]  vec
  );
    return {base, vec}; // RQ3
  endfunction

  function automatic pic_src_t src_of(
    input logic [6:0]  v,
    input logic [15:0] l0,
    input logic [15:0] l1
  );
    pic_src_t    s;
    logic [6:0]  p;
    s = '{en: 1'b0, lvl: 2'b00};
    p = v - `PIC_VEC_PERIPH;
    if (v >= `PIC_VEC_CORE_FIRST && v <= `PIC_VEC_CORE_LAST) begin
      s = '{en: 1'b1, lvl: 2'b11}; // RQ5
    end else if (v == `PIC_VEC_DBG_STEP) begin
      s = prog_level(l0[`PIC_F_DBG_STEP +: 2]); // RQ15
    end else if (v == `PIC_VEC_DBG_BKPT) begin
      s = prog_level(l0[`PIC_F_DBG_BKPT +: 2]); // RQ15
    end else if (v == `PIC_VEC_DBG_TRACE) begin
      s = prog_level(l0[`PIC_F_DBG_TRACE +: 2]); // RQ15
    end else if (v == `PIC_VEC_DBG_TX) begin
      s = prog_level(l0[`PIC_F_DBG_TX +: 2]); // RQ14
    end else if (v == `PIC_VEC_DBG_RX) begin
      s = prog_level(l0[`PIC_F_DBG_RX +: 2]); // RQ14
    end else if (v == `PIC_VEC_SOFT2) begin
      s = '{en: 1'b1, lvl: 2'b10};
    end else if (v == `PIC_VEC_SOFT1) begin
      s = '{en: 1'b1, lvl: 2'b01};
    end else if (v == `PIC_VEC_SOFT_LOW) begin
      s = '{en: 1'b1, lvl: 2'b00};
    end else if (v == `PIC_VEC_CLKGEN) begin
      s = prog_level(l0[`PIC_F_CLKGEN +: 2]); // RQ13
    end else if (v == `PIC_VEC_LOWVOLT) begin
      s = prog_level(l0[`PIC_F_LOWVOLT +: 2]); // RQ13
    end else if (v >= `PIC_VEC_PERIPH) begin
      s = periph_level(l1[{p[2:0], 1'b0} +: 2]);
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // register bank state
  // ----------------------------------------------------------------
  logic [15:0] level0_reg;
  logic [15:0] level0_next;
  logic [15:0] level1_reg;
  logic [15:0] level1_next;
  logic [13:0] vbase_reg;
  logic [13:0] vbase_next;
  logic [6:0]  fast0_reg;
  logic [6:0]  fast0_next;
  logic [6:0]  fast1_reg;
  logic [6:0]  fast1_next;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    level0_next  = level0_reg;
    level1_next  = level1_reg;
    vbase_next   = vbase_reg;
    fast0_next   = fast0_reg;
    fast1_next   = fast1_reg;
    rd_data_next = 16'h0000;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `PIC_OFS_LEVEL0: begin
          // reserved 11-10 forced low whatever is written
          level0_next = bus_req.wdata & `PIC_LEVEL0_WMASK; // RQ16
        end
        `PIC_OFS_LEVEL1: begin
          level1_next = bus_req.wdata;
        end
        `PIC_OFS_VBASE: begin
          vbase_next = bus_req.wdata[13:0]; // RQ18
        end
        `PIC_OFS_FAST0: begin
          fast0_next = bus_req.wdata[6:0]; // RQ11
        end
        `PIC_OFS_FAST1: begin
          fast1_next = bus_req.wdata[6:0]; // RQ11
        end
        default: begin
          // unmapped write does nothing
        end
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PIC_OFS_LEVEL0: begin
          rd_data_next = level0_reg;
        end
        `PIC_OFS_LEVEL1: begin
          rd_data_next = level1_reg;
        end
        `PIC_OFS_VBASE: begin
          rd_data_next = {2'b00, vbase_reg}; // RQ18
        end
        `PIC_OFS_FAST0: begin
          rd_data_next = {9'h000, fast0_reg};
        end
        `PIC_OFS_FAST1: begin
          rd_data_next = {9'h000, fast1_reg};
        end
        `PIC_OFS_CTRL: begin
          rd_data_next = {core_out.level_code, // RQ9
                          core_out.request,
                          core_out.fast,
                          5'h00,
                          core_out.vector};
        end
        default: begin
          rd_data_next = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      level0_reg  <= `PIC_LEVEL_RESET; // RQ12
      level1_reg  <= `PIC_LEVEL_RESET;
      vbase_reg   <= `PIC_VBASE_DEFAULT; // RQ18
      fast0_reg   <= `PIC_FAST_RESET;
      fast1_reg   <= `PIC_FAST_RESET;
      rd_data_reg <= 16'h0000;
    end else begin
      level0_reg  <= level0_next;
      level1_reg  <= level1_next;
      vbase_reg   <= vbase_next;
      fast0_reg   <= fast0_next;
      fast1_reg   <= fast1_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // a strap-like reset base cannot be loaded under async reset,
  // so the parameter only drives the base until the first edge after release, and vbase_reg still resets to PIC_VBASE_DEFAULT
  logic base_loaded_reg;
  logic base_loaded_next;
  logic [13:0] base_eff;

  always_comb begin
    base_loaded_next = 1'b1;
    base_eff = base_loaded_reg ? vbase_reg : VBASE_RESET;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      base_loaded_reg <= 1'b0;
    end else begin
      base_loaded_reg <= base_loaded_next;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic           win_found;
  logic [6:0]     win_vec;
  pic_level_t     win_lvl;
  pic_level_t     mask_floor;
  pic_src_t       src;
  pic_core_out_t  core_next;
  pic_core_out_t  core_reg;
  logic [20:0]    chip_rst_next;
  logic [20:0]    wdog_rst_next;
  logic [20:0]    chip_rst_reg;
  logic [20:0]    wdog_rst_reg;

  always_comb begin
    win_found = 1'b0;
    win_vec   = 7'h00;
    win_lvl   = 2'b00;
    src       = '{en: 1'b0, lvl: 2'b00};
    // scan downward; >= lets the lower vector take a tie
    for (int v = `PIC_NUM_VEC - 1; v >= 0; v--) begin
      src = src_of(7'(v), level0_reg, level1_reg);
      if (irq_req[v] && src.en) begin // RQ17
        if (!win_found || src.lvl >= win_lvl) begin // RQ1 RQ2
          win_found = 1'b1;
          win_vec   = 7'(v);
          win_lvl   = src.lvl;
        end
      end
    end
    mask_floor = {mask_bit_high, mask_bit_low};
    // nesting: only levels at or above the core mask go out
    core_next.request = win_found && win_lvl >= mask_floor; // RQ7 RQ8
    core_next.vector  = win_vec;
    core_next.vector_addr = form_addr(base_eff, win_vec); // RQ3 RQ4
    core_next.fast = win_found && win_lvl == 2'b10 &&
                     (win_vec == fast0_reg ||
                      win_vec == fast1_reg); // RQ10
    if (!win_found || win_vec == `PIC_VEC_SOFT_LOW) begin
      core_next.level_code = 2'b00; // RQ9
    end else if (win_lvl == 2'b00) begin
      core_next.level_code = 2'b01; // RQ9
    end else if (win_lvl == 2'b01) begin
      core_next.level_code = 2'b10; // RQ9
    end else begin
      core_next.level_code = 2'b11; // RQ9
    end
    chip_rst_next = form_addr(base_eff, `PIC_VEC_CHIP_RST); // RQ4
    wdog_rst_next = form_addr(base_eff, `PIC_VEC_WDOG_RST); // RQ4
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      core_reg     <= '0;
      chip_rst_reg <= 21'h000000;
      wdog_rst_reg <= 21'h000001;
    end else begin
      core_reg     <= core_next;
      chip_rst_reg <= chip_rst_next;
      wdog_rst_reg <= wdog_rst_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign core_out      = core_reg;
  assign rd_data       = rd_data_reg;
  assign chip_rst_addr = chip_rst_reg;
  assign wdog_rst_addr = wdog_rst_reg;

endmodule // pic_irq_arbiter

// >>> verification/pic_src_model.sv
// request sources and core mask bits facing the arbiter
`timescale 1ns/10ps
module pic_src_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [25:0] src_set,
  input  wire logic [1:0]  mask_set,
  output      logic [25:0] irq_req,
  output      logic        mask_bit_high,
  output      logic        mask_bit_low
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_req <= 26'h0;
      {mask_bit_high, mask_bit_low} <= 2'h0;
    end else begin
      irq_req <= src_set;
      {mask_bit_high, mask_bit_low} <= mask_set;
    end
  end
endmodule // pic_src_model

// >>> verification/pic_irq_arbiter_asserts.sv
// checker on the arbiter ports
`timescale 1ns/10ps
module pic_chk (
  input wire logic                   clock,
  input wire logic                   reset,
  input wire pic_pkg::pic_bus_req_t  bus_req,
  input wire logic [15:0]            rd_data,
  input wire logic [25:0]            irq_req,
  input wire logic                   mask_bit_high,
  input wire logic                   mask_bit_low,
  input wire pic_pkg::pic_core_out_t core_out,
  input wire logic [20:0]            chip_rst_addr,
  input wire logic [20:0]            wdog_rst_addr
);
  import pic_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_addr;
    core_out.vector_addr[6:0] == core_out.vector;
  endproperty
  a_addr: assert property (p_addr) else $error("vector address tail wrong");
  property p_base;
    core_out.vector_addr[20:7] == chip_rst_addr[20:7] &&
    chip_rst_addr[6:0] == 7'h00 && wdog_rst_addr == (chip_rst_addr | 21'h1);
  endproperty
  a_base: assert property (p_base) else $error("table base mismatch");
  property p_core;
    !$past(reset) && $past(irq_req[5:2]) != 4'h0 |-> core_out.request &&
    core_out.level_code == 2'h3 && core_out.vector inside {[7'h02:7'h05]};
  endproperty
  a_core: assert property (p_core) else $error("core exception lost");
  property p_low;
    !$past(reset) && $past(irq_req[2]) |-> core_out.vector == 7'h02;
  endproperty
  a_low: assert property (p_low) else $error("lowest vector lost");
  property p_idle;
    !$past(reset) && $past(irq_req) == 26'h0 |-> !core_out.request &&
    !core_out.fast && core_out.level_code == 2'h0 && core_out.vector == 7'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("request with no source");
  property p_mask;
    !$past(reset) && core_out.request |->
    $past({mask_bit_high, mask_bit_low}) == 2'h0 ||
    core_out.level_code > $past({mask_bit_high, mask_bit_low}) ||
    core_out.level_code == 2'h3;
  endproperty
  a_mask: assert property (p_mask) else $error("masked level taken");
  property p_soft0;
    !$past(reset) && $past(irq_req) == 26'h2000 |-> core_out.vector == 7'h0d &&
    core_out.level_code == 2'h0 &&
    core_out.request == ($past({mask_bit_high, mask_bit_low}) == 2'h0);
  endproperty
  a_soft0: assert property (p_soft0) else $error("soft level code wrong");
  property p_fast;
    core_out.fast |-> core_out.level_code == 2'h3 &&
    !(core_out.vector inside {[7'h02:7'h05]});
  endproperty
  a_fast: assert property (p_fast) else $error("fast flag on wrong level");
  property p_rsvd;
    $past(bus_req.rd) && $past(bus_req.addr) == 4'h0 |-> rd_data[11:10] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
endmodule // pic_chk
bind pic_irq_arbiter pic_chk u_chk (
  .clock(clock), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
  .irq_req(irq_req), .mask_bit_high(mask_bit_high),
  .mask_bit_low(mask_bit_low), .core_out(core_out),
  .chip_rst_addr(chip_rst_addr), .wdog_rst_addr(wdog_rst_addr));

// >>> verification/tb_pic_irq_arbiter.sv
// self-checking bench of the interrupt arbiter
`timescale 1ns/10ps
module tb_pic_irq_arbiter;
  import pic_pkg::*;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  pic_bus_req_t  bus_req = '0;
  logic [15:0]   rd_data;
  logic [25:0]   irq_req, src = 26'h0;
  logic [1:0]    mask = 2'h0;
  logic          mask_bit_high, mask_bit_low;
  pic_core_out_t core_out;
  logic [20:0]   chip_rst_addr, wdog_rst_addr;
  int            error_cnt = 0, n_compared = 0;
  int            l0 = 0, l1 = 0, f0 = 0, f1 = 0, base = 0;
  always #5 clock = ~clock;
  pic_src_model u_src (.clock(clock), .reset(reset), .src_set(src),
    .mask_set(mask), .irq_req(irq_req), .mask_bit_high(mask_bit_high),
    .mask_bit_low(mask_bit_low));
  pic_irq_arbiter dut (.clock(clock), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .irq_req(irq_req), .mask_bit_high(mask_bit_high),
    .mask_bit_low(mask_bit_low), .core_out(core_out),
    .chip_rst_addr(chip_rst_addr), .wdog_rst_addr(wdog_rst_addr));
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ---------------------------------------------
  // reference arbitration from levels and sources
  // ---------------------------------------------
  function automatic pic_core_out_t model();
    int c, lv, bl, bv;
    pic_core_out_t o;
    bl = -1;
    bv = 0;
    for (int v = 2; v < 26; v++) begin
      lv = -1;
      c = v < 11 ? (l0 >> (2 * (v - 6))) & 3 : v == 16 ? (l0 >> 14) & 3 :
          v == 17 ? (l0 >> 12) & 3 : 0;
      if (v < 6) lv = 3;
      else if (v < 11 || v == 16 || v == 17) lv = c == 0 ? -1 : c;
      else if (v < 14) lv = 13 - v;
      else if (v > 17) lv = ((l1 >> (2 * (v - 18))) & 3) - 1;
      if (src[v] && lv > bl) begin
        bl = lv;
        bv = v;
      end
    end
    o.request = bl >= 0 && bl >= mask;
    o.fast = bl == 2 && (bv == f0 || bv == f1);
    o.level_code = (bl < 0 || bv == 13) ? 2'h0 : bl == 3 ? 2'h3 : 2'(bl + 1);
    o.vector = 7'(bv);
    o.vector_addr = {base[13:0], 7'(bv)};
    return o;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    bus_req <= '0;
    case (a)
      4'h0: l0 = d & 16'hf3ff;
      4'h1: l1 = d;
      4'h7: base = d & 16'h3fff;
      4'h8: f0 = d & 16'h7f;
      4'h9: f1 = d & 16'h7f;
      default: ;
    endcase
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus_req <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge clock);
    bus_req <= '0;
    #1;
    cmp_reg(rd_data, e);
    @(posedge clock);
  endtask
  // one stage in the source model plus one in the arbiter, then margin
  task automatic chk_core(input logic [25:0] s, input logic [1:0] m);
    pic_core_out_t o;
    src <= s;
    mask <= m;
    repeat (4) @(posedge clock);
    #1;
    o = model();
    cmp_out(core_out, o);
    cmp_out({11'h0, chip_rst_addr}, {11'h0, base[13:0], 7'h00});
    cmp_out({11'h0, wdog_rst_addr}, {11'h0, base[13:0], 7'h01});
    @(posedge clock);
    rd(4'ha, {o.level_code, o.request, o.fast, 5'h00, o.vector});
  endtask
  task automatic results();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    int v, sh;
    logic [31:0] r;
    void'($urandom(77783));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(4'h0, 16'h0);
    rd(4'h7, 16'h0);
    rd(4'hf, 16'h0);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hf3ff);
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h3fff);
    chk_core(26'h4, 2'h0);
    wr(4'h0, 16'h0002);
    wr(4'h8, 16'h0006);
    chk_core(26'h40, 2'h1);
    chk_core(26'h2000, 2'h0);
    chk_core(26'h2000, 2'h1);
    // each level0 field lifted alone above the fixed level-2 source
    for (int i = 0; i < 7; i++) begin
      v = i < 5 ? 6 + i : 11 + i;
      sh = i < 5 ? 2 * i : 24 - 2 * i;
      wr(4'h0, 16'h3 << sh);
      chk_core(26'h800 | (26'h1 << v), 2'h0);
      wr(4'h0, 16'h0);
      chk_core(26'h1 << v, 2'h0);
    end
    for (int n = 0; n < 300; n++) begin
      r = $urandom;
      if (r[0]) wr(4'h0, r[31:16] & 16'hf3ff);
      if (r[1]) wr(4'h1, r[31:16]);
      if (r[2]) wr({3'h4, r[3]}, 16'($urandom_range(6, 25)));
      if (r[4]) wr(4'h7, r[31:16] & 16'h3fff);
      chk_core(26'($urandom & $urandom) & (r[5] ? 26'h3ffffc3 : 26'h3ffffff),
               r[7:6]);
    end
    rd(4'h0, 16'(l0));
    rd(4'h1, 16'(l1));
    rd(4'h7, 16'(base));
    rd(4'h8, 16'(f0));
    rd(4'h9, 16'(f1));
    results();
  end
endmodule // tb_pic_irq_arbiter
